// File: secondary_irq_pkg.sv
// Constants for the secondary interrupt status and mask block
// Behaviour
// RULE1 - Thermal warning bit 1 sets on either edge
// RULE2 - Writing one clears status bit; zero keeps
// RULE3 - Set mask bit blocks its primary line
// RULE4 - Status one bits record regardless of mask
// RULE5 - All mask bits reset to one
// RULE6 - Mask zero passes event, one blocks
// RULE7 - Sixteen pin status bits feed pin primary
// RULE8 - Pin trigger condition comes from outside logic
// RULE9 - Pin status captures regardless of mask
// RULE10 - Each pin has own mask, same position
// RULE11 - Pins documented 1..12; all sixteen implemented
// RULE12 - Button bit 12 sets on either edge
// RULE13 - Timeout bit 11 sets on rising edge
// RULE14 - Masks gate primary only, never status
// RULE15 - Primary high while unmasked status set
// RULE16 - Sources synchronised; event beats clear
package secondary_irq_pkg;

   localparam int unsigned ADR_W = 17;
   localparam int unsigned IDX_W = 15;
   localparam int unsigned REG_W = 16;

   // Printed register indices; byte address is four times the index
   localparam logic [14:0] IDX_STATUS_ONE = 15'h4011;
   localparam logic [14:0] IDX_PIN_STATUS = 15'h4015;
   localparam logic [14:0] IDX_MASK_ONE   = 15'h4019;
   localparam logic [14:0] IDX_PIN_MASK   = 15'h401d;
   localparam logic [14:0] IDX_SUMM_STAT  = 15'h4020;
   localparam logic [14:0] IDX_SUMM_MASK  = 15'h4021;

   // Field positions in the first status and mask registers
   localparam int unsigned THERM_BIT   = 1;
   localparam int unsigned TIMEOUT_BIT = 11;
   localparam int unsigned BUTTON_BIT  = 12;

   // Summary register layout, one bit per primary line
   localparam int unsigned SUM_THERM   = 0;
   localparam int unsigned SUM_PIN     = 1;
   localparam int unsigned SUM_BUTTON  = 2;
   localparam int unsigned SUM_TIMEOUT = 3;
   localparam int unsigned SUM_W       = 4;

   // Source index inside the synchroniser vectors
   localparam int unsigned SRC_THERM   = 0;
   localparam int unsigned SRC_BUTTON  = 1;
   localparam int unsigned SRC_TIMEOUT = 2;
   localparam int unsigned SRC_N       = 3;

   // Reset values
   localparam logic [15:0] MASK_RESET   = 16'hffff;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [3:0]  SUMM_MASK_RESET = 4'hf;
   localparam logic [3:0]  SUMM_RESET   = 4'h0;

endpackage

// File: secondary_irq_status_mask.sv
// Secondary interrupt status and mask registers behind a Wishbone slave
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module secondary_irq_status_mask (
   input  wire logic        sys_clk,             // System clock, 200 MHz
   input  wire logic        arst_n,              // Asynchronous reset, active low
   input  wire logic [16:0] wb_adr_i,            // Byte address
   input  wire logic [31:0] wb_dat_i,            // Write data
   input  wire logic [3:0]  wb_sel_i,            // Byte lane selects
   input  wire logic        wb_we_i,             // Write when high
   input  wire logic        wb_cyc_i,            // Bus cycle
   input  wire logic        wb_stb_i,            // Strobe
   output logic      [31:0] wb_dat_o,            // Read data
   output logic             wb_ack_o,            // Acknowledge
   input  wire logic        thermal_warning_in,  // Thermal warning level, async
   input  wire logic        button_pin_in,       // Power-button pin level, async
   input  wire logic        timeout_in,          // Watchdog timeout level, async
   input  wire logic [15:0] pin_event_n,         // Qualified pin event pulses
   output logic             thermal_primary_irq, // Thermal primary line
   output logic             pin_primary_irq,     // Pin primary line
   output logic             button_primary_irq,  // Button primary line
   output logic             timeout_primary_irq, // Timeout primary line
   output logic             irq                  // Summary interrupt
);

   // Edge detect arming and source events
   logic [2:0]  warm_reg;
   logic        armed;
   logic        thermal_warning_event;
   logic        button_edge_event;
   logic        timeout_event;

   // Register file
   logic [15:0] status_one_reg;
   logic [15:0] pin_status_reg;
   logic [15:0] mask_one_reg;
   logic [15:0] pin_mask_reg;
   logic [3:0]  summ_reg;
   logic [3:0]  summ_mask_reg;
   logic        ack_reg;
   logic [31:0] rd_data_reg;
   logic        irq_reg;

   // Primary lines and their previous values
   logic [3:0]  prim_next;
   logic [3:0]  prim_reg;
   logic [3:0]  prim_rise;

   // Bus decode
   logic        req;
   logic        take;
   logic        done;
   logic [14:0] word_idx;
   logic        hit_status_one;
   logic        hit_pin_status;
   logic        hit_mask_one;
   logic        hit_pin_mask;
   logic        hit_summ_stat;
   logic        hit_summ_mask;
   logic [15:0] lane;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] set_one;
   logic [15:0] clr_one;
   logic [15:0] clr_pin;
   logic [3:0]  clr_summ;
   logic [31:0] rd_data;

   // Edges ignored until the pipeline holds real samples,
   // so a level already high at reset is not a false edge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         warm_reg <= 3'h0;
      end else begin
         warm_reg <= {warm_reg[1:0], 1'b1};
      end
   end

   assign armed = warm_reg[2];

   // One synchroniser per source; thermal and button count both edges
   level_edge_sync #(
      .BOTH_EDGES (1'b1)
   ) u_thermal_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .level_in (thermal_warning_in),
      .armed    (armed),
      .edge_out (thermal_warning_event)  // [RULE1] [RULE16]
   );

   level_edge_sync #(
      .BOTH_EDGES (1'b1)
   ) u_button_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .level_in (button_pin_in),
      .armed    (armed),
      .edge_out (button_edge_event)  // [RULE12]
   );

   level_edge_sync #(
      .BOTH_EDGES (1'b0)
   ) u_timeout_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .level_in (timeout_in),
      .armed    (armed),
      .edge_out (timeout_event)  // [RULE13]
   );

   // Wishbone classic: ack one cycle after the request, then dropped
   assign req  = wb_cyc_i & wb_stb_i;
   assign take = req & ~ack_reg;
   assign done = req & ack_reg;

   assign word_idx       = wb_adr_i[16:2];
   assign hit_status_one = (word_idx == secondary_irq_pkg::IDX_STATUS_ONE);
   assign hit_pin_status = (word_idx == secondary_irq_pkg::IDX_PIN_STATUS);
   assign hit_mask_one   = (word_idx == secondary_irq_pkg::IDX_MASK_ONE);
   assign hit_pin_mask   = (word_idx == secondary_irq_pkg::IDX_PIN_MASK);
   assign hit_summ_stat  = (word_idx == secondary_irq_pkg::IDX_SUMM_STAT);
   assign hit_summ_mask  = (word_idx == secondary_irq_pkg::IDX_SUMM_MASK);

   // Writes land on the edge that completes the cycle
   assign wr    = done & wb_we_i;
   assign lane  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdata = wb_dat_i[15:0];

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take;
      end
   end

   assign wb_ack_o = ack_reg;

   // Event vector for the first status register
   always_comb begin
      set_one = 16'h0000;
      set_one[secondary_irq_pkg::THERM_BIT]   = thermal_warning_event; // [RULE1]
      set_one[secondary_irq_pkg::TIMEOUT_BIT] = timeout_event;         // [RULE13]
      set_one[secondary_irq_pkg::BUTTON_BIT]  = button_edge_event;     // [RULE12]
   end

   assign clr_one = (wr && hit_status_one) ? (wdata & lane) : 16'h0000; // [RULE2]
   assign clr_pin = (wr && hit_pin_status) ? (wdata & lane) : 16'h0000; // [RULE2]

   // Masks take no part, status always records
   sticky_status #(
      .W         (16),
      .RESET_VAL (secondary_irq_pkg::STATUS_RESET)
   ) u_status_one (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_in   (set_one),
      .clr_in   (clr_one),
      .stat_out (status_one_reg)  // [RULE4] [RULE14] [RULE16]
   );

   // Pin events arrive already qualified by each pin's trigger mode;
   // pins above twelve kept until their use is confirmed
   sticky_status #(
      .W         (16),
      .RESET_VAL (secondary_irq_pkg::STATUS_RESET)
   ) u_pin_status (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_in   (pin_event_n),
      .clr_in   (clr_pin),
      .stat_out (pin_status_reg)  // [RULE7] [RULE8] [RULE9] [RULE11]
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_one_reg <= secondary_irq_pkg::MASK_RESET; // [RULE5]
      end else if (wr && hit_mask_one) begin
         mask_one_reg <= (mask_one_reg & ~lane) | (wdata & lane);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_mask_reg <= secondary_irq_pkg::MASK_RESET; // [RULE5]
      end else if (wr && hit_pin_mask) begin
         pin_mask_reg <= (pin_mask_reg & ~lane) | (wdata & lane); // [RULE10]
      end
   end

   // Primary lines: unmasked status, mask one blocks
   always_comb begin
      prim_next = 4'h0;
      prim_next[secondary_irq_pkg::SUM_THERM] =
         status_one_reg[secondary_irq_pkg::THERM_BIT] &
         ~mask_one_reg[secondary_irq_pkg::THERM_BIT]; // [RULE3] [RULE6] [RULE15]
      prim_next[secondary_irq_pkg::SUM_PIN] =
         |(pin_status_reg & ~pin_mask_reg); // [RULE3] [RULE6] [RULE10] [RULE15]
      prim_next[secondary_irq_pkg::SUM_BUTTON] =
         status_one_reg[secondary_irq_pkg::BUTTON_BIT] &
         ~mask_one_reg[secondary_irq_pkg::BUTTON_BIT]; // [RULE3] [RULE12] [RULE15]
      prim_next[secondary_irq_pkg::SUM_TIMEOUT] =
         status_one_reg[secondary_irq_pkg::TIMEOUT_BIT] &
         ~mask_one_reg[secondary_irq_pkg::TIMEOUT_BIT]; // [RULE3] [RULE13] [RULE15]
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prim_reg <= 4'h0;
      end else begin
         prim_reg <= prim_next;
      end
   end

   assign thermal_primary_irq = prim_reg[secondary_irq_pkg::SUM_THERM];
   assign pin_primary_irq     = prim_reg[secondary_irq_pkg::SUM_PIN];
   assign button_primary_irq  = prim_reg[secondary_irq_pkg::SUM_BUTTON];
   assign timeout_primary_irq = prim_reg[secondary_irq_pkg::SUM_TIMEOUT];

   // Summary bits latch each primary line rising
   assign prim_rise = prim_next & ~prim_reg;

   // Read clears only the bits that were returned, so a bit set
   // between capture and ack is kept for the next read
   assign clr_summ = (done && !wb_we_i && hit_summ_stat) ? rd_data_reg[3:0] : 4'h0;

   sticky_status #(
      .W         (secondary_irq_pkg::SUM_W),
      .RESET_VAL (secondary_irq_pkg::SUMM_RESET)
   ) u_summary (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_in   (prim_rise),
      .clr_in   (clr_summ),
      .stat_out (summ_reg)
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         summ_mask_reg <= secondary_irq_pkg::SUMM_MASK_RESET;
      end else if (wr && hit_summ_mask && wb_sel_i[0]) begin
         summ_mask_reg <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(summ_reg & ~summ_mask_reg);
      end
   end

   assign irq = irq_reg;

   // Read mux; unmapped words read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit_status_one) begin
         rd_data[15:0] = status_one_reg;
      end else if (hit_pin_status) begin
         rd_data[15:0] = pin_status_reg;
      end else if (hit_mask_one) begin
         rd_data[15:0] = mask_one_reg;
      end else if (hit_pin_mask) begin
         rd_data[15:0] = pin_mask_reg;
      end else if (hit_summ_stat) begin
         rd_data[3:0] = summ_reg;
      end else if (hit_summ_mask) begin
         rd_data[3:0] = summ_mask_reg;
      end
   end

   // Data captured with the request and held until the next one
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_reg <= 32'h0000_0000;
      end else if (take) begin
         rd_data_reg <= rd_data;
      end
   end

   assign wb_dat_o = rd_data_reg;

endmodule

// Two-flop synchroniser with edge detect for one asynchronous level
module level_edge_sync #(
   parameter bit BOTH_EDGES = 1'b1
) (
   input  wire logic sys_clk,  // System clock
   input  wire logic arst_n,   // Asynchronous reset, active low
   input  wire logic level_in, // Asynchronous level
   input  wire logic armed,    // High once the pipeline holds real samples
   output logic      edge_out  // One-cycle pulse on a detected edge
);

   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // Only sync2_reg reads sync1_reg, so no logic sees a metastable value
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= level_in; // [RULE16]
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= sync2_reg;
      end
   end

   // Falling edges count only where the source asks for both
   assign edge_out = armed & (sync2_reg ^ prev_reg) & (BOTH_EDGES | sync2_reg); // [RULE16]

endmodule

// Sticky status word: a set in the same cycle as a clear wins
module sticky_status #(
   parameter int unsigned  W         = 16,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         sys_clk,  // System clock
   input  wire logic         arst_n,   // Asynchronous reset, active low
   input  wire logic [W-1:0] set_in,   // Event bits
   input  wire logic [W-1:0] clr_in,   // Bits to clear
   output logic      [W-1:0] stat_out  // Status word
);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_out <= RESET_VAL;
      end else begin
         stat_out <= (stat_out & ~clr_in) | set_in; // [RULE16]
      end
   end

endmodule

`default_nettype wire

// File: secondary_irq_status_mask_monitor.sv
// Checker of bus timing and primary line behaviour
`timescale 1ns/1ps
`default_nettype none
module secondary_irq_status_mask_monitor (
   input wire logic        sys_clk,             // Clock
   input wire logic        arst_n,              // Reset
   input wire logic [16:0] wb_adr_i,            // Address
   input wire logic [31:0] wb_dat_i,            // Write data
   input wire logic [3:0]  wb_sel_i,            // Lanes
   input wire logic        wb_we_i,             // Write
   input wire logic        wb_cyc_i,            // Cycle
   input wire logic        wb_stb_i,            // Strobe
   input wire logic [31:0] wb_dat_o,            // Read data
   input wire logic        wb_ack_o,            // Ack
   input wire logic        thermal_warning_in,  // Thermal
   input wire logic        button_pin_in,       // Button
   input wire logic        timeout_in,          // Timeout
   input wire logic [15:0] pin_event_n,         // Pin events
   input wire logic        thermal_primary_irq, // Thermal line
   input wire logic        pin_primary_irq,     // Pin line
   input wire logic        button_primary_irq,  // Button line
   input wire logic        timeout_primary_irq, // Timeout line
   input wire logic        irq                  // Summary
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic req;
   logic mapped;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign mapped = wb_adr_i[16:2] inside {15'h4011, 15'h4015, 15'h4019, 15'h401d, 15'h4020, 15'h4021};
   chk_ack_follows: assert property (req |=> wb_ack_o)
      else $error("no ack after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   chk_dat_held: assert property (!req |=> $stable(wb_dat_o))
      else $error("read data moved without request");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_therm_fall: assert property ($fell(thermal_primary_irq) |-> $past(wb_we_i && wb_ack_o, 2))
      else $error("thermal line fell without write");
   chk_button_fall: assert property ($fell(button_primary_irq) |-> $past(wb_we_i && wb_ack_o, 2))
      else $error("button line fell without write");
   chk_timeout_fall: assert property ($fell(timeout_primary_irq) |-> $past(wb_we_i && wb_ack_o, 2))
      else $error("timeout line fell without write");
   chk_pin_fall: assert property ($fell(pin_primary_irq) |-> $past(wb_we_i && wb_ack_o, 2))
      else $error("pin line fell without write");
   chk_pin_rise: assert property ($rose(pin_primary_irq) |-> $past(|pin_event_n, 2) || $past(wb_we_i && wb_ack_o, 2))
      else $error("pin line rose without cause");
   cov_therm: cover property ($rose(thermal_primary_irq));
   cov_pin: cover property ($rose(pin_primary_irq));
   cov_irq: cover property ($rose(irq));
endmodule
bind secondary_irq_status_mask secondary_irq_status_mask_monitor u_mon (.sys_clk, .arst_n, .wb_adr_i, .wb_dat_i,
   .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .thermal_warning_in, .button_pin_in, .timeout_in,
   .pin_event_n, .thermal_primary_irq, .pin_primary_irq, .button_primary_irq, .timeout_primary_irq, .irq);
`default_nettype wire

// File: secondary_irq_status_mask_bench.sv
// Self-checking bench for the secondary interrupt block
`timescale 1ns/1ps
`default_nettype none
module secondary_irq_status_mask_bench;
   localparam logic [14:0] ST1 = secondary_irq_pkg::IDX_STATUS_ONE;
   localparam logic [14:0] PST = secondary_irq_pkg::IDX_PIN_STATUS;
   localparam logic [14:0] MK1 = secondary_irq_pkg::IDX_MASK_ONE;
   localparam logic [14:0] PMK = secondary_irq_pkg::IDX_PIN_MASK;
   localparam logic [14:0] SST = secondary_irq_pkg::IDX_SUMM_STAT;
   localparam logic [14:0] SMK = secondary_irq_pkg::IDX_SUMM_MASK;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [16:0] wb_adr_i = 17'h0_0000;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        thermal_warning_in = 1'b0;
   logic        button_pin_in = 1'b0;
   logic        timeout_in = 1'b0;
   logic [15:0] pin_event_n = 16'h0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, thermal_primary_irq, pin_primary_irq, button_primary_irq, timeout_primary_irq, irq;
   int          err_total = 0;
   int          n_compared = 0;
   int          cycles = 0;

   secondary_irq_status_mask dut (.sys_clk, .arst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
      .wb_stb_i, .wb_dat_o, .wb_ack_o, .thermal_warning_in, .button_pin_in, .timeout_in, .pin_event_n,
      .thermal_primary_irq, .pin_primary_irq, .button_primary_irq, .timeout_primary_irq, .irq);

   always #2.5 sys_clk = ~sys_clk;

   // Hang guard, far above the few hundred cycles used
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_line(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // One classic cycle; entered just after an edge
   task automatic bus(input logic [14:0] idx, input logic we, input logic [3:0] sel, input logic [15:0] d,
                      output logic [15:0] q);
      wb_adr_i <= {idx, 2'b00};
      wb_we_i  <= we;
      wb_dat_i <= {16'h0000, d};
      wb_sel_i <= sel;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [14:0] idx, input logic [15:0] d);
      logic [15:0] q;
      bus(idx, 1'b1, 4'hf, d, q);
   endtask

   task automatic wrl(input logic [14:0] idx, input logic [3:0] sel, input logic [15:0] d);
      logic [15:0] q;
      bus(idx, 1'b1, sel, d, q);
   endtask

   task automatic rd(input logic [14:0] idx, input logic [15:0] exp);
      logic [15:0] q;
      bus(idx, 1'b0, 4'hf, 16'h0000, q);
      chk(q, exp);
   endtask

   task automatic t_reset();
      rd(MK1, 16'hffff);
      rd(PMK, 16'hffff);
      rd(ST1, 16'h0000);
      rd(SMK, 16'h000f);
      rd(15'h4030, 16'h0000);
      rd(PST, 16'h0000);
      rd(SST, 16'h0000);
      // Byte lanes are written independently
      wrl(MK1, 4'h1, 16'h1234);
      rd(MK1, 16'hff34);
      wrl(PMK, 4'h2, 16'h0000);
      rd(PMK, 16'h00ff);
      wrl(SMK, 4'he, 16'h0000);
      rd(SMK, 16'h000f);
      wr(MK1, 16'hffff);
      wr(PMK, 16'hffff);
      rd(MK1, 16'hffff);
   endtask

   task automatic t_thermal();
      thermal_warning_in <= 1'b1;
      wt(8);
      rd(ST1, 16'h0002);
      chk_line(thermal_primary_irq, 1'b0);
      wr(ST1, 16'h0000);
      rd(ST1, 16'h0002);
      wr(ST1, 16'h0002);
      rd(ST1, 16'h0000);
      thermal_warning_in <= 1'b0;
      wt(8);
      rd(ST1, 16'h0002);
      wr(MK1, 16'hfffd);
      wr(SMK, 16'h0000);
      wt(3);
      chk_line(thermal_primary_irq, 1'b1);
      chk_line(irq, 1'b1);
      wr(ST1, 16'h0002);
      wt(3);
      chk_line(thermal_primary_irq, 1'b0);
      rd(SST, 16'h0001);
      wt(3);
      chk_line(irq, 1'b0);
      wr(MK1, 16'hffff);
   endtask

   task automatic t_edges();
      button_pin_in <= 1'b1;
      timeout_in <= 1'b1;
      wt(8);
      rd(ST1, 16'h1800);
      wr(ST1, 16'h1800);
      button_pin_in <= 1'b0;
      timeout_in <= 1'b0;
      wt(8);
      rd(ST1, 16'h1000);
      wr(MK1, 16'hf7ff);
      timeout_in <= 1'b1;
      wt(8);
      chk_line(timeout_primary_irq, 1'b1);
      chk_line(button_primary_irq, 1'b0);
      wr(MK1, 16'he7ff);
      wt(3);
      chk_line(button_primary_irq, 1'b1);
      wr(ST1, 16'h1800);
      wt(3);
      chk_line(button_primary_irq, 1'b0);
      chk_line(timeout_primary_irq, 1'b0);
      wr(MK1, 16'hffff);
   endtask

   task automatic t_pins();
      pin_event_n <= 16'h8001;
      wt(1);
      pin_event_n <= 16'h0000;
      wt(2);
      rd(PST, 16'h8001);
      chk_line(pin_primary_irq, 1'b0);
      wr(PMK, 16'hfffe);
      wt(3);
      chk_line(pin_primary_irq, 1'b1);
      wr(PST, 16'h0001);
      wt(3);
      chk_line(pin_primary_irq, 1'b0);
      // Pulse lands on the edge where the clear takes effect
      fork
         wr(PST, 16'h8000);
         begin
            wt(1);
            pin_event_n <= 16'h8000;
            wt(1);
            pin_event_n <= 16'h0000;
         end
      join
      rd(PST, 16'h8000);
   endtask

   initial begin
      wt(16);
      arst_n <= 1'b1;
      wt(1);
      t_reset();
      t_thermal();
      t_edges();
      t_pins();
      give_verdict();
   end
endmodule
`default_nettype wire
